//--- common/fpau_pkg.sv
// Constants shared by the floating-point absolute/add execution unit
package fpau_pkg;
  // Instruction format and opcode values
  localparam logic [1:0] FMT_ARITH     = 2'h2;
  localparam logic [5:0] PRIMARY_FPOP  = 6'h34;
  localparam logic [8:0] XOP_ABS_S     = 9'h009;
  localparam logic [8:0] XOP_ABS_D     = 9'h00A;
  localparam logic [8:0] XOP_ABS_Q     = 9'h00B;
  localparam logic [8:0] XOP_ADD_S     = 9'h041;
  localparam logic [8:0] XOP_ADD_D     = 9'h042;
  localparam logic [8:0] XOP_ADD_Q     = 9'h043;
  // Instruction field positions
  localparam int FMT_HI = 31;
  localparam int FMT_LO = 30;
  localparam int RD_HI  = 29;
  localparam int RD_LO  = 25;
  localparam int PO_HI  = 24;
  localparam int PO_LO  = 19;
  localparam int SRC1_HI = 18;
  localparam int SRC1_LO = 14;
  localparam int XO_HI   = 13;
  localparam int XO_LO   = 5;
  localparam int SRC2_HI = 4;
  localparam int SRC2_LO = 0;
  // Trap type codes
  localparam logic [2:0] FTT_NONE       = 3'h0;
  localparam logic [2:0] FTT_IEEE       = 3'h1;
  localparam logic [2:0] FTT_INCOMPLETE = 3'h2;
  localparam logic [2:0] FTT_UNSUPPORT  = 3'h3;
  // Exception bit positions
  localparam int EX_NV = 4;
  localparam int EX_OF = 3;
  localparam int EX_UF = 2;
  localparam int EX_NX = 0;
  // Rounding directions
  localparam logic [1:0] RND_NEAR = 2'h0;
  localparam logic [1:0] RND_ZERO = 2'h1;
  localparam logic [1:0] RND_POS  = 2'h2;
  localparam logic [1:0] RND_NEG  = 2'h3;
  // Register word addresses, reset values and status bits
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  localparam logic [1:0] REG_MASK = 2'h2;
  localparam logic [1:0] REG_LAST = 2'h3;
  localparam logic       CTRL_RST = 1'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam int ST_DONE = 0;
  localparam int ST_IEEE = 1;
  localparam int ST_TRAP = 2;
endpackage : fpau_pkg

//--- src/fpau_core.sv
// Floating-point absolute value and add execution unit with Avalon slave
// Operation
// - Abs decoded from primary opcode and three precision extended opcodes.
// - Abs copies the source with the sign bit forced to zero.
// - Single is 32 bits, double 64 bits, quad 128 bits wide.
// - Completed abs clears current exception and trap type fields.
// - Abs never rounds, keeps accrued exceptions, treats NaN as plain bits.
// - Quad abs raises illegal instruction trap for software emulation.
// - Abs with nonzero first source field raises illegal instruction trap.
// - Either enable bit zero or no unit present raises unit-off trap.
// - Add decoded from same primary opcode and three precision opcodes.
// - Add sums both source operands into the destination register.
// - Add result rounds by the rounding direction field.
// - Enabled quad add raises misc trap with unsupported-op code.
// - Add may raise misc trap with incomplete-op code on odd operands.
// - Add reports overflow, underflow, inexact, invalid via IEEE trap.
// - Fields sit at fixed bit positions of the instruction word.
module fpau_core
  import fpau_pkg::*;
(
  input  wire logic         ref_clk,          // Core clock
  input  wire logic         rst_n,            // Async reset, active low
  input  wire logic         iss_valid,        // Instruction issued
  input  wire logic [31:0]  iss_instr,        // Instruction word
  input  wire logic [127:0] src1_opnd,        // First source operand
  input  wire logic [127:0] src2_opnd,        // Second source operand
  input  wire logic         fp_state_enable_bit, // Float state enable
  input  wire logic         proc_fp_enable,   // Processor state enable
  input  wire logic         unit_present,     // Float unit fitted
  input  wire logic [1:0]   rounding_direction_field, // Rounding mode
  input  wire logic [4:0]   trap_enable_mask, // IEEE trap enables
  input  wire logic [4:0]   cur_exc_in,       // Current exceptions now
  input  wire logic [4:0]   acc_exc_in,       // Accrued exceptions now
  output logic              res_valid,        // Claimed op finished
  output logic              res_wr,           // Destination write
  output logic [4:0]        res_dest,         // Destination register
  output logic [127:0]      res_data,         // Result value
  output logic              fsr_wr,           // Status fields update
  output logic [4:0]        current_exception_field, // New current exc
  output logic [2:0]        trap_type_field,  // New trap type
  output logic [4:0]        accrued_exception_field, // New accrued exc
  output logic              illegal_trap,     // Illegal instruction
  output logic              unit_off_trap,    // Float unit disabled
  output logic              misc_float_trap,  // Other float trap
  output logic              ieee_float_trap,  // IEEE exception trap
  input  wire logic [1:0]   avs_address,      // Register word address
  input  wire logic         avs_read,         // Bus read
  input  wire logic         avs_write,        // Bus write
  input  wire logic [31:0]  avs_writedata,    // Bus write data
  output logic [31:0]       avs_readdata,     // Bus read data
  output logic              avs_waitrequest,  // Bus stall
  output logic              irq               // Level interrupt
);

  // Split a word into sign, 11-bit exponent, left-aligned 52-bit fraction
  function automatic logic [63:0] fp_unpack(input logic [63:0] v,
                                            input logic dbl);
    if (dbl) begin
      return v;
    end
    return {v[31], 3'h0, v[30:23], v[22:0], 29'h0};
  endfunction : fp_unpack

  // Repack into the precision's own layout
  function automatic logic [63:0] fp_pack(input logic s,
                                          input logic [10:0] e,
                                          input logic [51:0] f,
                                          input logic dbl);
    if (dbl) begin
      return {s, e, f};
    end
    return {32'h0, s, e[7:0], f[51:29]};
  endfunction : fp_pack

  // Ones in every bit below position k
  function automatic logic [56:0] low_mask(input int k);
    return (57'h1 << k) - 57'h1;
  endfunction : low_mask

  // Add two operands; returns exception bits above the 64-bit result
  function automatic logic [68:0] fp_add(input logic [63:0] a,
                                         input logic [63:0] b,
                                         input logic dbl,
                                         input logic [1:0] rm);
    logic [63:0] ua, ub, t;
    logic [10:0] emax;
    logic [11:0] ea, eb, e, d;
    logic [55:0] ma, mb, mt;
    logic [56:0] s;
    logic [4:0]  x;
    logic        sz, na, nb, ia, ib, tiny, inx, up, g, st, big;
    int          p;
    x = '0;
    ua = fp_unpack(a, dbl);
    ub = fp_unpack(b, dbl);
    emax = dbl ? 11'h7FF : 11'h0FF;
    p = dbl ? 3 : 32;
    na = (ua[62:52] == emax) && (ua[51:0] != '0);
    nb = (ub[62:52] == emax) && (ub[51:0] != '0);
    ia = (ua[62:52] == emax) && (ua[51:0] == '0);
    ib = (ub[62:52] == emax) && (ub[51:0] == '0);
    if (na || nb) begin
      // Signalling NaN is invalid; the NaN passes on quieted
      x[EX_NV] = (na && !ua[51]) || (nb && !ub[51]);
      t = na ? ua : ub;
      return {x, fp_pack(t[63], emax, t[51:0] | 52'h8000000000000, dbl)};
    end
    if (ia && ib && (ua[63] != ub[63])) begin
      x[EX_NV] = 1'b1;
      return {x, fp_pack(1'b0, emax, '1, dbl)};
    end
    if (ia) begin
      return {x, fp_pack(ua[63], emax, '0, dbl)};
    end
    if (ib) begin
      return {x, fp_pack(ub[63], emax, '0, dbl)};
    end
    // Subnormals use exponent one without the hidden bit
    ea = {1'b0, ua[62:52] | {10'h0, ua[62:52] == '0}};
    eb = {1'b0, ub[62:52] | {10'h0, ub[62:52] == '0}};
    ma = {ua[62:52] != '0, ua[51:0], 3'h0};
    mb = {ub[62:52] != '0, ub[51:0], 3'h0};
    big = {ea, ma} >= {eb, mb};
    sz = big ? ua[63] : ub[63];
    e = big ? ea : eb;
    mt = big ? mb : ma;
    ma = big ? ma : mb;
    d = big ? ea - eb : eb - ea;
    // Alignment keeps a sticky bit so rounding sees every lost one
    if (d > 12'd55) begin
      mt = {55'h0, mt != '0};
    end else begin
      mt = (mt >> d) | {55'h0, (mt & low_mask(int'(d))) != '0};
    end
    if (ua[63] == ub[63]) begin
      s = {1'b0, ma} + {1'b0, mt};
    end else begin
      s = {1'b0, ma} - {1'b0, mt};
    end
    if (s == '0) begin
      up = (ua[63] == ub[63]) ? ua[63] : (rm == RND_NEG);
      return {x, fp_pack(up, 11'h0, '0, dbl)};
    end
    if (s[56]) begin
      s = {1'b0, s[56:1]} | {56'h0, s[0]};
      e = e + 12'h1;
    end
    // Normalise, stopping at the subnormal floor
    for (int i = 0; i < 56; i++) begin
      if (!s[55] && e > 12'h1) begin
        s = s << 1;
        e = e - 12'h1;
      end
    end
    tiny = !s[55];
    g = s[p-1];
    st = (s & low_mask(p - 1)) != '0;
    inx = g || st;
    unique case (rm)
      RND_NEAR: up = g && (st || s[p]);
      RND_ZERO: up = 1'b0;
      RND_POS:  up = inx && !sz;
      RND_NEG:  up = inx && sz;
    endcase
    s = s & ~low_mask(p);
    if (up) begin
      s = s + (57'h1 << p);
    end
    if (s[56]) begin
      s = s >> 1;
      e = e + 12'h1;
    end
    x[EX_UF] = tiny && inx;
    x[EX_NX] = inx;
    if (e >= {1'b0, emax}) begin
      x[EX_OF] = 1'b1;
      x[EX_NX] = 1'b1;
      if (rm == RND_NEAR || (rm == RND_POS && !sz) ||
          (rm == RND_NEG && sz)) begin
        return {x, fp_pack(sz, emax, '0, dbl)};
      end
      return {x, fp_pack(sz, emax - 11'h1, '1, dbl)};
    end
    return {x, fp_pack(sz, s[55] ? e[10:0] : 11'h0, s[54:3], dbl)};
  endfunction : fp_add

  logic         ctrl_sub_trap_ff;   // Trap adds on subnormal operands
  logic [2:0]   status_ff;          // Sticky events
  logic [2:0]   mask_ff;            // Interrupt mask
  logic [8:0]   xop;
  logic [4:0]   src1_fld;
  logic         op_hit, is_abs, is_add, is_quad, is_dbl, fpu_on;
  logic         sub_in, tr_ill, tr_off, tr_misc, tr_ieee, ok;
  logic [2:0]   misc_code;
  logic [68:0]  sum;
  logic [127:0] abs_val;
  logic         bus_go, wr_take;
  logic [2:0]   ev_set, ev_clr;

  assign xop = iss_instr[XO_HI:XO_LO];
  assign src1_fld = iss_instr[SRC1_HI:SRC1_LO];

  assign is_abs = xop == XOP_ABS_S || xop == XOP_ABS_D || xop == XOP_ABS_Q;
  assign is_add = xop == XOP_ADD_S || xop == XOP_ADD_D || xop == XOP_ADD_Q;
  assign op_hit = iss_valid && iss_instr[FMT_HI:FMT_LO] == FMT_ARITH &&
                  iss_instr[PO_HI:PO_LO] == PRIMARY_FPOP &&
                  (is_abs || is_add);
  assign is_quad = xop == XOP_ABS_Q || xop == XOP_ADD_Q;
  assign is_dbl = xop == XOP_ABS_D || xop == XOP_ADD_D;

  // illegal forms outrank the disabled unit
  assign tr_ill = op_hit && is_abs && (is_quad || src1_fld != '0);
  assign fpu_on = fp_state_enable_bit && proc_fp_enable && unit_present;
  assign tr_off = op_hit && !tr_ill && !fpu_on;

  // subnormal add operands punt to software when enabled
  assign sub_in = is_dbl ?
    (src1_opnd[62:52] == '0 && src1_opnd[51:0] != '0) ||
    (src2_opnd[62:52] == '0 && src2_opnd[51:0] != '0) :
    (src1_opnd[30:23] == '0 && src1_opnd[22:0] != '0) ||
    (src2_opnd[30:23] == '0 && src2_opnd[22:0] != '0);
  // quad add is unsupported once the unit is on
  assign tr_misc = op_hit && is_add && fpu_on &&
                   (is_quad || (ctrl_sub_trap_ff && sub_in));
  assign misc_code = is_quad ? FTT_UNSUPPORT : FTT_INCOMPLETE;

  // sum rounded by the live rounding mode
  assign sum = fp_add(src1_opnd[63:0], src2_opnd[63:0], is_dbl,
                      rounding_direction_field);
  // enabled IEEE exceptions trap instead of writing
  assign tr_ieee = op_hit && is_add && fpu_on && !tr_misc &&
                   (sum[68:64] & trap_enable_mask) != '0;
  assign ok = op_hit && !tr_ill && !tr_off && !tr_misc && !tr_ieee;

  // sign cleared at the precision's top bit
  assign abs_val = is_dbl ? {64'h0, 1'b0, src2_opnd[62:0]} :
                            {96'h0, 1'b0, src2_opnd[30:0]};

  // Destination write; one cycle after issue
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_valid <= 1'b0;
      res_wr <= 1'b0;
      res_dest <= '0;
      res_data <= '0;
    end else begin
      res_valid <= op_hit;
      res_wr <= ok;
      res_dest <= iss_instr[RD_HI:RD_LO];
      if (ok) begin
        res_data <= is_abs ? abs_val : {64'h0, sum[63:0]};
      end
    end
  end

  // Status field updates
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fsr_wr <= 1'b0;
      current_exception_field <= '0;
      trap_type_field <= FTT_NONE;
      accrued_exception_field <= '0;
    end else begin
      // illegal and disabled traps leave the fields alone
      fsr_wr <= ok || tr_misc || tr_ieee;
      current_exception_field <= cur_exc_in;
      trap_type_field <= FTT_NONE;
      accrued_exception_field <= acc_exc_in;
      if (tr_misc) begin
        trap_type_field <= misc_code;
      end else if (tr_ieee) begin
        current_exception_field <= sum[68:64];
        trap_type_field <= FTT_IEEE;
      end else if (ok && is_abs) begin
        current_exception_field <= '0;
      end else if (ok) begin
        current_exception_field <= sum[68:64];
        accrued_exception_field <= acc_exc_in | sum[68:64];
      end
    end
  end

  // Trap requests, one-cycle pulses
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      illegal_trap <= 1'b0;
      unit_off_trap <= 1'b0;
      misc_float_trap <= 1'b0;
      ieee_float_trap <= 1'b0;
    end else begin
      illegal_trap <= tr_ill;
      unit_off_trap <= tr_off;
      misc_float_trap <= tr_misc;
      ieee_float_trap <= tr_ieee;
    end
  end

  // Bus handshake: one wait state, then the access completes
  assign bus_go = (avs_read || avs_write) && avs_waitrequest;
  assign wr_take = avs_write && !avs_waitrequest;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else begin
      avs_waitrequest <= !bus_go;
      if (bus_go && avs_read) begin
        unique case (avs_address)
          REG_CTRL: avs_readdata <= {31'h0, ctrl_sub_trap_ff};
          REG_STAT: avs_readdata <= {29'h0, status_ff};
          REG_MASK: avs_readdata <= {29'h0, mask_ff};
          REG_LAST: avs_readdata <= {24'h0, trap_type_field,
                                     current_exception_field};
        endcase
      end
    end
  end

  // Software-written control and mask
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_sub_trap_ff <= CTRL_RST;
      mask_ff <= MASK_RST;
    end else if (wr_take) begin
      if (avs_address == REG_CTRL) begin
        ctrl_sub_trap_ff <= avs_writedata[0];
      end
      if (avs_address == REG_MASK) begin
        mask_ff <= avs_writedata[2:0];
      end
    end
  end

  // Sticky events; a new event beats a same-cycle clear
  assign ev_set = {res_valid && !res_wr && (illegal_trap ||
                   unit_off_trap || misc_float_trap),
                   ieee_float_trap, res_wr};
  assign ev_clr = (wr_take && avs_address == REG_STAT) ?
                  avs_writedata[2:0] : 3'h0;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= '0;
      irq <= 1'b0;
    end else begin
      status_ff <= (status_ff & ~ev_clr) | ev_set;
      irq <= ((status_ff & mask_ff) != '0);
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_abs_sign;
    op_hit && is_abs && !is_dbl && ok |=>
      res_wr && res_data[31:0] == {1'b0, $past(src2_opnd[30:0])};
  endproperty
  a_abs_sign: assert property (p_abs_sign)
    else $error("abs result not source with sign cleared");

  property p_abs_fsr;
    op_hit && is_abs && ok |=> fsr_wr && current_exception_field == '0 &&
      trap_type_field == FTT_NONE;
  endproperty
  a_abs_fsr: assert property (p_abs_fsr)
    else $error("abs did not clear exception and trap type");

  property p_abs_acc;
    op_hit && is_abs && ok |=> accrued_exception_field == $past(acc_exc_in);
  endproperty
  a_abs_acc: assert property (p_abs_acc)
    else $error("abs changed accrued exceptions");

  property p_quad_abs;
    op_hit && xop == XOP_ABS_Q |=> illegal_trap && !unit_off_trap;
  endproperty
  a_quad_abs: assert property (p_quad_abs)
    else $error("quad abs did not raise illegal trap");

  property p_src1_nz;
    op_hit && is_abs && src1_fld != '0 |=> illegal_trap && !res_wr;
  endproperty
  a_src1_nz: assert property (p_src1_nz)
    else $error("abs with nonzero first source executed");

  property p_off;
    op_hit && is_add && !fpu_on |=> unit_off_trap && !fsr_wr;
  endproperty
  a_off: assert property (p_off)
    else $error("disabled unit did not trap add");

  property p_quad_add;
    op_hit && xop == XOP_ADD_Q && fpu_on |=>
      misc_float_trap && trap_type_field == FTT_UNSUPPORT;
  endproperty
  a_quad_add: assert property (p_quad_add)
    else $error("quad add missing unsupported trap");

  property p_ieee;
    ieee_float_trap |-> trap_type_field == FTT_IEEE &&
      (current_exception_field & $past(trap_enable_mask)) != '0;
  endproperty
  a_ieee: assert property (p_ieee)
    else $error("IEEE trap without enabled exception");

  property p_no_wr;
    illegal_trap || unit_off_trap || misc_float_trap || ieee_float_trap
      |-> !res_wr;
  endproperty
  a_no_wr: assert property (p_no_wr)
    else $error("trapped instruction wrote destination");

endmodule : fpau_core

//--- verification/fpau_pipe_model.sv
// Pipeline side model: issues instructions and captures the answers
module fpau_pipe_model
  import fpau_pkg::*;
(
  input  wire logic         ref_clk,   // Core clock
  input  wire logic         rst_n,     // Async reset, active low
  input  wire logic         go,        // Bench asks for one issue
  input  wire logic [31:0]  cmd,       // Instruction to issue
  input  wire logic [127:0] opa,       // First operand to issue
  input  wire logic [127:0] opb,       // Second operand to issue
  output logic              iss_valid, // Issue strobe
  output logic [31:0]       iss_instr, // Issued word
  output logic [127:0]      src1_opnd, // Issued first operand
  output logic [127:0]      src2_opnd, // Issued second operand
  input  wire logic         res_valid, // Answer strobe
  input  wire logic [23:0]  res_bits,  // Packed answer flags and fields
  input  wire logic [127:0] res_data,  // Answer value
  output logic [23:0]       cap_bits,  // Last answer flags and fields
  output logic [127:0]      cap_data,  // Last answer value
  output logic [7:0]        cap_cnt    // Answers seen so far
);
  // One word per request; idle lines invert so stale values never match
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      iss_valid <= 1'b0;
      iss_instr <= 32'h0;
      src1_opnd <= 128'h0;
      src2_opnd <= 128'h0;
    end else begin
      iss_valid <= go;
      iss_instr <= go ? cmd : ~iss_instr;
      src1_opnd <= go ? opa : ~src1_opnd;
      src2_opnd <= go ? opb : ~src2_opnd;
    end
  end

  // Answers stand one cycle only, so take them in that cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_bits <= 24'h0;
      cap_data <= 128'h0;
      cap_cnt  <= 8'h0;
    end else if (res_valid) begin
      cap_bits <= res_bits;
      cap_data <= res_data;
      cap_cnt  <= cap_cnt + 8'h1;
    end
  end
endmodule : fpau_pipe_model

//--- verification/fpau_core_tb.sv
// Self-checking bench for the float absolute value and add unit
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  mismatches++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module fpau_core_tb
  import fpau_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] RD = 5'h15;
  logic        ref_clk, rst_n, go, iss_valid, res_valid, res_wr, fsr_wr, irq;
  logic        illegal_trap, unit_off_trap, misc_float_trap, ieee_float_trap;
  logic        fp_state_enable_bit, proc_fp_enable, unit_present;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [1:0]  rounding_direction_field, avs_address;
  logic [2:0]  trap_type_field;
  logic [4:0]  trap_enable_mask, cur_exc_in, acc_exc_in, res_dest;
  logic [4:0]  current_exception_field, accrued_exception_field;
  logic [7:0]  cap_cnt;
  logic [23:0] cap_bits;
  logic [31:0] cmd, rdat, iss_instr, avs_writedata, avs_readdata;
  logic [127:0] opa, opb, src1_opnd, src2_opnd, res_data, cap_data;
  int          mismatches, num_checks;
  bit          got;

  fpau_core i_fpau_core (.ref_clk, .rst_n, .iss_valid, .iss_instr,
    .src1_opnd, .src2_opnd, .fp_state_enable_bit, .proc_fp_enable,
    .unit_present, .rounding_direction_field, .trap_enable_mask,
    .cur_exc_in, .acc_exc_in, .res_valid, .res_wr, .res_dest, .res_data,
    .fsr_wr, .current_exception_field, .trap_type_field,
    .accrued_exception_field, .illegal_trap, .unit_off_trap,
    .misc_float_trap, .ieee_float_trap, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq);

  fpau_pipe_model i_fpau_pipe_model (.ref_clk, .rst_n, .go, .cmd, .opa,
    .opb, .iss_valid, .iss_instr, .src1_opnd, .src2_opnd, .res_valid,
    .res_bits({res_wr, fsr_wr, res_dest, current_exception_field,
               trap_type_field, accrued_exception_field, illegal_trap,
               unit_off_trap, misc_float_trap, ieee_float_trap}),
    .res_data, .cap_bits, .cap_data, .cap_cnt);

  // 200 MHz core clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Bus access: request held until waitrequest is sampled low
  task automatic bus(input bit wr, input logic [1:0] a, input logic [31:0] wd);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) `CHK("bus answer", 1'b0, 1'b1)
  endtask : bus

  // One issue through the pipeline model; bounded wait for its answer
  task automatic do_op(input logic [8:0] xo, input logic [4:0] f1,
                       input logic [127:0] a, b);
    logic [7:0] c0;
    int n;
    c0 = cap_cnt;
    @(posedge ref_clk);
    go <= 1'b1;
    cmd <= {FMT_ARITH, RD, PRIMARY_FPOP, f1, xo, 5'h03};
    opa <= a;
    opb <= b;
    @(posedge ref_clk);
    go <= 1'b0;
    n = 0;
    while (cap_cnt === c0 && n < 8) begin
      @(posedge ref_clk);
      n++;
    end
    got = (cap_cnt !== c0);
  endtask : do_op

  // Issue and judge: wf is {result write, status write}
  task automatic run(input logic [8:0] xo, input logic [4:0] f1,
                     input logic [127:0] a, b, d, input logic [1:0] wf,
                     input logic [12:0] fld, input logic [3:0] tr);
    do_op(xo, f1, a, b);
    `CHK("answer", 1'b1, got)
    `CHK("traps", tr, cap_bits[3:0])
    `CHK("writes", wf, cap_bits[23:22])
    `CHK("dest", RD, cap_bits[21:17])
    if (wf[1]) `CHK("data", d, cap_data)
    if (wf[0]) `CHK("fields", fld, cap_bits[16:4])
  endtask : run

  // Register reset values, sticky status, mask and interrupt level
  task automatic t_irq;
    bus(1'b0, REG_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h0, rdat)
    bus(1'b0, REG_MASK, 32'h0);
    `CHK("mask reset", 32'h0, rdat)
    bus(1'b0, REG_STAT, 32'h0);
    `CHK("status reset", 32'h0, rdat)
    trap_enable_mask <= 5'h08;
    run(XOP_ADD_S, 5'h02, 128'h7F7F_FFFF, 128'h7F7F_FFFF, 128'h0,
        2'b01, {5'h09, 3'h1, 5'h04}, 4'h1);
    trap_enable_mask <= 5'h00;
    bus(1'b0, REG_STAT, 32'h0);
    `CHK("status ieee", 32'h2, rdat)
    `CHK("irq masked", 1'b0, irq)
    bus(1'b1, REG_MASK, 32'h2);
    bus(1'b0, REG_LAST, 32'h0);
    // Fields idle between ops: no trap type, live current exceptions
    `CHK("last fields", 8'h0A, rdat[7:0])
    `CHK("irq raised", 1'b1, irq)
    bus(1'b1, REG_STAT, 32'h2);
    bus(1'b0, REG_STAT, 32'h0);
    `CHK("status cleared", 32'h0, rdat)
    `CHK("irq cleared", 1'b0, irq)
    $display("t_irq done");
  endtask : t_irq

  // Sign cleared, upper operand bits ignored, NaN copied as bits
  task automatic t_abs;
    run(XOP_ABS_S, 5'h00, 128'h0,
        {96'hA5A5_5A5A_0F0F_F0F0_1234_5678, 32'hC049_0FDB},
        {96'h0, 32'h4049_0FDB}, 2'b11, {5'h00, 3'h0, 5'h04}, 4'h0);
    run(XOP_ABS_D, 5'h00, 128'h0,
        {64'h0123_4567_89AB_CDEF, 64'hFFF8_0000_0000_0001},
        {64'h0, 64'h7FF8_0000_0000_0001}, 2'b11, {5'h00, 3'h0, 5'h04}, 4'h0);
    $display("t_abs done");
  endtask : t_abs

  // Sums in both precisions, every rounding mode, invalid without trap
  task automatic t_add;
    run(XOP_ADD_S, 5'h02, 128'h3F80_0000, 128'h4000_0000,
        128'h4040_0000, 2'b11, {5'h00, 3'h0, 5'h04}, 4'h0);
    run(XOP_ADD_D, 5'h02, 128'h3FF0_0000_0000_0000,
        128'h4000_0000_0000_0000, 128'h4008_0000_0000_0000, 2'b11,
        {5'h00, 3'h0, 5'h04}, 4'h0);
    for (int m = 0; m < 4; m++) begin
      rounding_direction_field <= 2'(m);
      run(XOP_ADD_S, 5'h02, 128'h3F80_0000, 128'h3380_0000,
          {96'h0, 32'h3F80_0000 + 32'(m == 2)}, 2'b11,
          {5'h01, 3'h0, 5'h05}, 4'h0);
    end
    rounding_direction_field <= RND_NEAR;
    run(XOP_ADD_S, 5'h02, 128'h7F80_0000, 128'hFF80_0000,
        128'h7FFF_FFFF, 2'b11, {5'h10, 3'h0, 5'h14}, 4'h0);
    $display("t_add done");
  endtask : t_add

  // Illegal, unit-off and misc traps leave the destination alone; misc traps still write status
  task automatic t_traps;
    run(XOP_ABS_Q, 5'h00, 128'h0, 128'h1, 128'h0, 2'b00, 13'h0, 4'h8);
    run(XOP_ABS_S, 5'h01, 128'h0, 128'h1, 128'h0, 2'b00, 13'h0, 4'h8);
    run(XOP_ADD_Q, 5'h02, 128'h1, 128'h1, 128'h0, 2'b01,
        {5'h0A, 3'h3, 5'h04}, 4'h2);
    bus(1'b1, REG_CTRL, 32'h1);
    run(XOP_ADD_S, 5'h02, 128'h1, 128'h3F80_0000, 128'h0, 2'b01,
        {5'h0A, 3'h2, 5'h04}, 4'h2);
    bus(1'b1, REG_CTRL, 32'h0);
    for (int i = 0; i < 3; i++) begin
      {fp_state_enable_bit, proc_fp_enable, unit_present} <= ~(3'h1 << i);
      run(i == 1 ? XOP_ADD_D : XOP_ABS_S, 5'h00, 128'h1, 128'h1,
          128'h0, 2'b00, 13'h0, 4'h4);
    end
    {fp_state_enable_bit, proc_fp_enable, unit_present} <= 3'h7;
    do_op(9'h008, 5'h00, 128'h1, 128'h1);
    `CHK("ignored op", 1'b0, got)
    $display("t_traps done");
  endtask : t_traps

  // Counts, verdict and end of run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // Main sequence after an 8-cycle reset
  initial begin
    rst_n = 1'b0;
    go = 1'b0;
    cmd = 32'h0;
    opa = 128'h0;
    opb = 128'h0;
    {fp_state_enable_bit, proc_fp_enable, unit_present} = 3'h7;
    rounding_direction_field = RND_NEAR;
    trap_enable_mask = 5'h00;
    cur_exc_in = 5'h0A;
    acc_exc_in = 5'h04;
    avs_address = 2'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_irq;
    t_abs;
    t_add;
    t_traps;
    wrap_up;
  end

  // Watchdog: the tests need well under 1000 cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    wrap_up;
  end
endmodule : fpau_core_tb
